// File: shared/torque_block_defines.svh
// constants for the safe torque-off return control
// Operation
// R1 - safety request forces hardware torque block
// R2 - return only with all safety inputs on
// R3 - return only with servo-on command off
// R4 - no return during polarity detection request
// R5 - no return while servo-on utility runs
// R6 - inputs on with servo-on keeps block; host gates servo-on with servo ready, so it is off while blocked
// R7 - after reset apply function after init
// R8 - after recalculation apply function per inputs
// R9 - permanent servo-on prevents any return
// R10 - stop method follows stop mode field
// R11 - safe function cancels zero-speed stopping
// R12 - group-two alarm during function: field stop
// R13 - overtravel inactive while function operates
// R14 - servo ready low until block cleared
// R15 - brake delay ignored, block entered directly
// R16 - older bus command warning on entry
// R17 - newer bus warning on entry or cancel
// R18 - all return conditions checked same cycle
`ifndef TORQUE_BLOCK_DEFINES_SVH
`define TORQUE_BLOCK_DEFINES_SVH
`define TB_ADDR_CTRL     32'h0000_0000
`define TB_ADDR_STATUS   32'h0000_0004
`define TB_ADDR_EVENT    32'h0000_0008
`define TB_ADDR_MASK     32'h0000_000c
`define TB_CTRL_SVON     0
`define TB_CTRL_MOTION   1
`define TB_CTRL_RESET    2
`define TB_CTRL_CANCEL   3
`define TB_CTRL_NEWBUS   4
`define TB_CTRL_RESET_VAL 5'h00
`define TB_EVT_ENTRY     0
`define TB_EVT_RETURN    1
`define TB_EVT_WARN      2
`define TB_MASK_RESET_VAL 3'h0
`define TB_STOP_DB_DB    2'h0
`define TB_STOP_DB_COAST 2'h1
`define TB_STOP_COAST    2'h2
`define TB_SAFE_WIDTH    2
`endif

// File: shared/torque_block_pkg.sv
// types for the safe torque-off return control
package torque_block_pkg;
  typedef enum logic [2:0] {
    STOP_NONE     = 3'b001,
    STOP_DYNAMIC  = 3'b010,
    STOP_COAST    = 3'b100
  } brake_type;
endpackage : torque_block_pkg

// File: shared/torque_block_if.sv
// link between drive safety block and host motion controller
`timescale 1ns/1ps
`default_nettype none
interface torque_block_if;
  logic [1:0] safeRequest;
  logic       servoOnCommand;
  logic       polarityRequest;
  logic       motionActive;
  logic       cancelBit;
  logic       alarmReset;
  logic       newBus;
  logic       servoReady;
  logic       hardwareTorqueBlock;
  logic       commandWarning;
  modport drive (input safeRequest, servoOnCommand, polarityRequest, motionActive, cancelBit,
                 alarmReset, newBus, output servoReady, hardwareTorqueBlock, commandWarning);
  modport host (output safeRequest, servoOnCommand, polarityRequest, motionActive, cancelBit,
                alarmReset, newBus, input servoReady, hardwareTorqueBlock, commandWarning);
endinterface : torque_block_if
`default_nettype wire

// File: core/sync_two_stage.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  // clocking
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  initial if (WIDTH < 1) $error("width must be positive");
  always_comb
  begin
    meta_d = ce ? asyncIn : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign syncOut = sync_q;
endmodule : sync_two_stage
`default_nettype wire

// File: core/torque_block_drive.sv
// drive end: hardware torque block entry, return and stop selection
`timescale 1ns/1ps
`default_nettype none
`include "torque_block_defines.svh"
module torque_block_drive #(
  parameter int SAFE_INPUTS = `TB_SAFE_WIDTH
) (
  // clocking
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // link
  torque_block_if.drive            link,
  // drive status
  input  wire logic                initBusy,
  input  wire logic                recalcBusy,
  input  wire logic                utilityServoOn,
  input  wire logic                permanentServoOn,
  input  wire logic [1:0]          stopModeField,
  input  wire logic                groupTwoAlarm,
  input  wire logic                overtravel,
  input  wire logic                brakeToServoOffDelay,
  // drive actions
  output logic                     safeTorqueBlockFunction,
  output torque_block_pkg::brake_type brakeAction,
  output logic                     zeroSpeedStop,
  output logic                     overtravelStop,
  output logic                     ordinaryTorqueBlockState
);
  logic [SAFE_INPUTS-1:0] safeSync;
  logic [5:0]             ctrlSync;
  logic                   block_q;
  logic                   block_d;
  logic                   warn_q;
  logic                   warn_d;
  logic                   ready_q;
  logic                   ready_d;
  logic                   zero_q;
  logic                   zero_d;
  logic                   ot_q;
  logic                   ot_d;
  logic                   ordinary_q;
  logic                   ordinary_d;
  torque_block_pkg::brake_type brake_q;
  torque_block_pkg::brake_type brake_d;
  logic                   request;
  logic                   settled;
  logic                   canReturn;
  logic                   motionLike;
  logic                   servoOnSync;
  logic                   motionSync;
  logic                   alarmResetSync;
  logic                   cancelSync;
  logic                   newBusSync;
  logic                   polaritySync;

  initial if (SAFE_INPUTS != `TB_SAFE_WIDTH) $error("safety input width must match the link");

  sync_two_stage #(.WIDTH(SAFE_INPUTS)) safeSyncInst (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .asyncIn (link.safeRequest),
    .syncOut (safeSync)
  );
  sync_two_stage #(.WIDTH(6)) ctrlSyncInst (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .asyncIn ({link.polarityRequest, link.newBus, link.cancelBit, link.alarmReset, link.motionActive,
               link.servoOnCommand}),
    .syncOut (ctrlSync)
  );
  // the polarity request comes straight from a pin, so it shares the same two stages
  assign servoOnSync    = ctrlSync[0];
  assign motionSync     = ctrlSync[1];
  assign alarmResetSync = ctrlSync[2];
  assign cancelSync     = ctrlSync[3];
  assign newBusSync     = ctrlSync[4];
  assign polaritySync   = ctrlSync[5];

  function automatic torque_block_pkg::brake_type stopOf(input logic [1:0] mode, input logic stopped);
    if (mode == `TB_STOP_COAST)
      stopOf = torque_block_pkg::STOP_COAST;
    else if (mode == `TB_STOP_DB_COAST && stopped)
      stopOf = torque_block_pkg::STOP_COAST;
    else
      stopOf = torque_block_pkg::STOP_DYNAMIC;
  endfunction : stopOf

  always_comb
  begin
    // inputs low mean a safety request; held until init or recalculation finishes
    settled    = !initBusy && !recalcBusy; // R7 R8
    request    = !(&safeSync); // R1
    canReturn  = (&safeSync) && !servoOnSync && !polaritySync && !utilityServoOn
                 && !permanentServoOn; // R2 R3 R4 R5 R9 R18
    motionLike = servoOnSync || motionSync;
  end

  // a request in the same cycle as a return keeps the block, since entry is tested first
  always_comb
  begin
    block_d = block_q;
    if (settled && request)
      block_d = 1'b1; // R1 R15
    else if (settled && block_q && canReturn)
      block_d = 1'b0; // R6 R18
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      block_q <= 1'b1;
    end
    else if (ce)
    begin
      block_q <= block_d;
    end
  end

  // older bus: warning on entry during a command; newer bus also on cancel
  // an alarm reset while still blocked is ignored, so the warning outlives the block
  always_comb
  begin
    warn_d = warn_q;
    if (!block_q && block_d && motionLike)
      warn_d = 1'b1; // R16 R17
    else if (newBusSync && cancelSync && motionLike)
      warn_d = 1'b1; // R17
    else if (alarmResetSync && !block_q && !(newBusSync && cancelSync))
      warn_d = 1'b0; // R16 R17
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      warn_q <= 1'b0;
    end
    else if (ce)
    begin
      warn_q <= warn_d;
    end
  end

  // ready waits one cycle past the return, so it never overlaps the block
  always_comb
  begin
    ready_d    = !block_q && !block_d && settled; // R14
    ordinary_d = !block_d && !servoOnSync; // R6
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready_q    <= 1'b0;
      ordinary_q <= 1'b0;
    end
    else if (ce)
    begin
      ready_q    <= ready_d;
      ordinary_q <= ordinary_d;
    end
  end

  // mode 1 brakes for one cycle after entry, then lets the motor coast
  always_comb
  begin
    zero_d = groupTwoAlarm && !block_d; // R11 R12
    ot_d   = overtravel && !block_d; // R13
    if (block_d)
      brake_d = stopOf(stopModeField, brake_q != torque_block_pkg::STOP_NONE); // R10 R11 R12 R13
    else
      brake_d = torque_block_pkg::STOP_NONE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zero_q  <= 1'b0;
      ot_q    <= 1'b0;
      brake_q <= torque_block_pkg::STOP_DYNAMIC;
    end
    else if (ce)
    begin
      zero_q  <= zero_d;
      ot_q    <= ot_d;
      brake_q <= brake_d;
    end
  end

  // brake delay input is deliberately unused while the function holds the block
  logic unusedDelay;
  assign unusedDelay              = brakeToServoOffDelay; // R15
  assign link.hardwareTorqueBlock = block_q;
  assign link.servoReady          = ready_q;
  assign link.commandWarning      = warn_q;
  assign safeTorqueBlockFunction  = request && settled;
  assign brakeAction              = brake_q;
  assign zeroSpeedStop            = zero_q;
  assign overtravelStop           = ot_q;
  assign ordinaryTorqueBlockState = ordinary_q;
endmodule : torque_block_drive
`default_nettype wire

// File: core/torque_block_host.sv
// host end: AXI4-Lite registers driving servo and motion commands
`timescale 1ns/1ps
`default_nettype none
`include "torque_block_defines.svh"
module torque_block_host (
  // clocking
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // user side
  input  wire logic [1:0]  safetySwitch,
  input  wire logic        polarityRequest,
  output logic             irq,
  // link
  torque_block_if.host     link
);
  logic [4:0]  ctrl_q, ctrl_d;
  logic [2:0]  evt_q, evt_d;
  logic [2:0]  mask_q, mask_d;
  logic        awHave_q, awHave_d, wHave_q, wHave_d, bv_q, bv_d, rv_q, rv_d;
  logic [31:0] awa_q, awa_d, wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [2:0]  st_q, st_d;

  always_comb
  begin
    awHave_d = awHave_q;
    wHave_d  = wHave_q;
    awa_d    = awa_q;
    wd_d     = wd_q;
    bv_d     = bv_q && !bready;
    br_d     = br_q;
    rv_d     = rv_q && !rready;
    rr_d     = rr_q;
    rd_d     = rd_q;
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    st_d     = {link.commandWarning, link.servoReady, link.hardwareTorqueBlock};
    evt_d    = evt_q;
    if (awvalid && awready)
    begin
      awHave_d = 1'b1;
      awa_d    = awaddr;
    end
    if (wvalid && wready)
    begin
      wHave_d = 1'b1;
      wd_d    = wdata;
    end
    if (awHave_q && wHave_q && !bv_q)
    begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bv_d     = 1'b1;
      br_d     = 2'h0;
      if (awa_q == `TB_ADDR_CTRL)
      begin
        if (wstrb[0] || 1'b1)
          ctrl_d = wd_q[4:0];
      end
      else if (awa_q == `TB_ADDR_MASK)
        mask_d = wd_q[2:0];
      else if (awa_q != `TB_ADDR_STATUS && awa_q != `TB_ADDR_EVENT)
        br_d = 2'h2;
    end
    if (arvalid && arready)
    begin
      rv_d = 1'b1;
      rr_d = 2'h0;
      if (araddr == `TB_ADDR_CTRL)
        rd_d = {27'h0, ctrl_q};
      else if (araddr == `TB_ADDR_STATUS)
        rd_d = {29'h0, st_q};
      else if (araddr == `TB_ADDR_EVENT)
        rd_d = {29'h0, evt_q};
      else if (araddr == `TB_ADDR_MASK)
        rd_d = {29'h0, mask_q};
      else
      begin
        rd_d = 32'h0;
        rr_d = 2'h2;
      end
    end
    // read clears events; a new event in the same cycle wins
    if (arvalid && arready && araddr == `TB_ADDR_EVENT)
      evt_d = 3'h0;
    if (!st_q[0] && st_d[0])
      evt_d[`TB_EVT_ENTRY] = 1'b1;
    if (st_q[0] && !st_d[0])
      evt_d[`TB_EVT_RETURN] = 1'b1;
    if (!st_q[2] && st_d[2])
      evt_d[`TB_EVT_WARN] = 1'b1; // R16 R17
    // alarm reset is a one-shot once the warning drops
    if (ctrl_q[`TB_CTRL_RESET] && !link.commandWarning)
      ctrl_d[`TB_CTRL_RESET] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= `TB_CTRL_RESET_VAL;
      evt_q <= 3'h0; mask_q <= `TB_MASK_RESET_VAL;
      awHave_q <= 1'b0; wHave_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= 32'h0; wd_q <= 32'h0; rd_q <= 32'h0;
      br_q <= 2'h0; rr_q <= 2'h0; st_q <= 3'h1;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d; evt_q <= evt_d; mask_q <= mask_d;
      awHave_q <= awHave_d; wHave_q <= wHave_d; bv_q <= bv_d; rv_q <= rv_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d; st_q <= st_d;
    end
  end

  assign awready = ce && !awHave_q;
  assign wready  = ce && !wHave_q;
  assign arready = ce && !rv_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign rvalid  = rv_q;
  assign rresp   = rr_q;
  assign rdata   = rd_q;
  assign irq     = |(evt_q & mask_q);
  // servo-on is only honoured while ready, so a return is never blocked by it
  assign link.safeRequest     = safetySwitch; // R2
  assign link.servoOnCommand  = ctrl_q[`TB_CTRL_SVON] && link.servoReady; // R3 R6
  assign link.polarityRequest = polarityRequest; // R4
  assign link.motionActive    = ctrl_q[`TB_CTRL_MOTION] && !link.hardwareTorqueBlock;
  assign link.cancelBit       = ctrl_q[`TB_CTRL_CANCEL]; // R17
  assign link.alarmReset      = ctrl_q[`TB_CTRL_RESET]; // R16
  assign link.newBus          = ctrl_q[`TB_CTRL_NEWBUS];
endmodule : torque_block_host
`default_nettype wire

// File: testbench/torque_block_properties.sv
// link checker for the safe torque-off return control
`timescale 1ns/1ps
`default_nettype none
module torque_block_properties (
  // clocking
  input wire logic       clk,
  input wire logic       rst,
  // host to drive
  input wire logic [1:0] safeRequest,
  input wire logic       servoOnCommand,
  input wire logic       polarityRequest,
  input wire logic       motionActive,
  input wire logic       cancelBit,
  input wire logic       alarmReset,
  input wire logic       newBus,
  // drive to host
  input wire logic       servoReady,
  input wire logic       hardwareTorqueBlock,
  input wire logic       commandWarning
);
  logic [2:0] onRun_q;
  logic [2:0] onRun_d;
  // run of cycles with every input on; synchroniser lag means a return needs at least two
  always_comb onRun_d = (rst || safeRequest != 2'h3) ? 3'h0 : onRun_q + {2'h0, onRun_q != 3'h7};
  always_ff @(posedge clk) onRun_q <= onRun_d;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_request_held;
    (safeRequest != 2'h3) [*4];
  endsequence
  sequence s_return;
    $fell(hardwareTorqueBlock);
  endsequence
  property p_block_on_request; s_request_held |-> ##[0:40] hardwareTorqueBlock; endproperty
  a_block_on_request: assert property (p_block_on_request) else $error("block missing");
  property p_return_inputs; s_return |-> onRun_q >= 3'h2; endproperty
  a_return_inputs: assert property (p_return_inputs) else $error("return with input off");
  property p_return_servo_off; s_return |-> !$past(servoOnCommand); endproperty
  a_return_servo_off: assert property (p_return_servo_off) else $error("return with servo on");
  property p_return_no_polarity; s_return |-> !$past(polarityRequest) && !polarityRequest; endproperty
  a_return_no_polarity: assert property (p_return_no_polarity) else $error("return in detection");
  property p_ready_low; hardwareTorqueBlock |=> !servoReady; endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready while blocked");
  property p_ready_back; s_return |=> servoReady; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back");
  property p_warn_entry; $rose(hardwareTorqueBlock) && $past(motionActive) |-> ##[0:3] commandWarning; endproperty
  a_warn_entry: assert property (p_warn_entry) else $error("no warning on entry");
  property p_warn_cancel; newBus && $rose(cancelBit) |-> ##[1:6] commandWarning; endproperty
  a_warn_cancel: assert property (p_warn_cancel) else $error("no warning on cancel");
  property p_warn_release; $fell(commandWarning) && !newBus |-> $past(alarmReset); endproperty
  a_warn_release: assert property (p_warn_release) else $error("warning dropped alone");
endmodule : torque_block_properties
`default_nettype wire

// File: testbench/safe_torque_off_return_control_tb.sv
// bench joining host and drive ends over the link
`timescale 1ns/1ps
`default_nettype none
`include "torque_block_defines.svh"
module safe_torque_off_return_control_tb;
  localparam logic [31:0] CTRL = `TB_ADDR_CTRL;
  localparam logic [31:0] STAT = `TB_ADDR_STATUS;
  localparam logic [31:0] EVT  = `TB_ADDR_EVENT;
  localparam logic [31:0] MSK  = `TB_ADDR_MASK;
  logic        clk = 1'h0, rst = 1'h1, irq, safeFn, zeroStop, otStop, ordBlock;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, lastResp, safetySwitch = 2'h3, stopModeField = 2'h0;
  logic        polarityRequest = 1'h0, initBusy = 1'h1, recalcBusy = 1'h0, utilityServoOn = 1'h0;
  logic        permanentServoOn = 1'h0, groupTwoAlarm = 1'h0, overtravel = 1'h0, brakeDelay = 1'h1;
  torque_block_pkg::brake_type brake;
  int          fail_count = 0;
  int          compares = 0;
  always #25 clk = ~clk;
  torque_block_if link ();
  torque_block_host torque_block_host_inst (.clk, .rst, .ce(1'h1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .safetySwitch, .polarityRequest, .irq, .link);
  torque_block_drive torque_block_drive_inst (.clk, .rst, .ce(1'h1), .link, .initBusy, .recalcBusy,
    .utilityServoOn, .permanentServoOn, .stopModeField, .groupTwoAlarm, .overtravel,
    .brakeToServoOffDelay(brakeDelay), .safeTorqueBlockFunction(safeFn), .brakeAction(brake),
    .zeroSpeedStop(zeroStop), .overtravelStop(otStop), .ordinaryTorqueBlockState(ordBlock));
  torque_block_properties torque_block_properties_inst (.clk, .rst, .safeRequest(link.safeRequest),
    .servoOnCommand(link.servoOnCommand), .polarityRequest(link.polarityRequest),
    .motionActive(link.motionActive), .cancelBit(link.cancelBit), .alarmReset(link.alarmReset),
    .newBus(link.newBus), .servoReady(link.servoReady), .hardwareTorqueBlock(link.hardwareTorqueBlock),
    .commandWarning(link.commandWarning));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_brake(input torque_block_pkg::brake_type got, input torque_block_pkg::brake_type exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask : chk_brake
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    lastResp = bresp;
    bready <= 1'h0;
  endtask : axi_write
  task automatic expect_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    rd = rdata;
    lastResp = rresp;
    rready <= 1'h0;
    chk(rd & m, e);
  endtask : expect_reg
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    expect_reg(STAT, 32'h7, 32'h1);
    expect_reg(MSK, 32'h7, 32'h0);
    expect_reg(32'h40, 32'h0, 32'h0);
    chk({30'h0, lastResp}, 32'h2);
    axi_write(32'h40, 32'h0);
    chk({30'h0, lastResp}, 32'h2);
    initBusy <= 1'h0;
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h2);
    expect_reg(EVT, 32'h2, 32'h2);
    expect_reg(EVT, 32'h2, 32'h0);
    $display("reset test done");
    axi_write(MSK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // each mode also tries one alarm case and one blocker on the way back
    for (int m = 0; m < 3; m++)
    begin
      stopModeField <= m[1:0];
      groupTwoAlarm <= (m == 0);
      overtravel <= (m == 2);
      wait_cyc(3);
      chk({31'h0, zeroStop}, m == 0 ? 32'h1 : 32'h0);
      chk({31'h0, otStop}, m == 2 ? 32'h1 : 32'h0);
      safetySwitch <= 2'h2 >> m;
      wait_cyc(2);
      groupTwoAlarm <= 1'h1;
      wait_cyc(10);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, safeFn}, 32'h1);
      chk({31'h0, zeroStop}, 32'h0);
      chk({31'h0, otStop}, 32'h0);
      chk_brake(brake, m == 0 ? torque_block_pkg::STOP_DYNAMIC : torque_block_pkg::STOP_COAST);
      expect_reg(STAT, 32'h7, 32'h1);
      chk({31'h0, ordBlock}, 32'h0);
      expect_reg(EVT, 32'h1, 32'h1);
      wait_cyc(2);
      chk({31'h0, irq}, 32'h0);
      groupTwoAlarm <= 1'h0;
      overtravel <= 1'h0;
      polarityRequest <= (m == 0);
      utilityServoOn <= (m == 1);
      permanentServoOn <= (m == 2);
      safetySwitch <= 2'h3;
      wait_cyc(10);
      chk({31'h0, safeFn}, 32'h0);
      expect_reg(STAT, 32'h7, 32'h1);
      polarityRequest <= 1'h0;
      utilityServoOn <= 1'h0;
      permanentServoOn <= 1'h0;
      wait_cyc(10);
      expect_reg(STAT, 32'h7, 32'h2);
      chk({31'h0, ordBlock}, 32'h1);
    end
    $display("stop mode test done");
    recalcBusy <= 1'h1;
    safetySwitch <= 2'h0;
    wait_cyc(5);
    expect_reg(STAT, 32'h7, 32'h0);
    recalcBusy <= 1'h0;
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h1);
    safetySwitch <= 2'h3;
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h2);
    $display("recalculation test done");
    axi_write(CTRL, 32'h3);
    wait_cyc(5);
    safetySwitch <= 2'h1;
    wait_cyc(10);
    expect_reg(STAT, 32'h5, 32'h5);
    axi_write(CTRL, 32'h0);
    safetySwitch <= 2'h3;
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h6);
    axi_write(CTRL, 32'h4);
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h2);
    axi_write(CTRL, 32'h13);
    wait_cyc(5);
    axi_write(CTRL, 32'h1b);
    wait_cyc(10);
    expect_reg(STAT, 32'h4, 32'h4);
    axi_write(CTRL, 32'h10);
    axi_write(CTRL, 32'h14);
    wait_cyc(10);
    expect_reg(STAT, 32'h7, 32'h2);
    $display("command warning test done");
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : safe_torque_off_return_control_tb
`default_nettype wire
